//--- verilog/flash_guard_consts.svh
// Purpose: offsets, field positions, reset values and sizes of the flash block guard
// Assumes: 64k-byte blocks, 16-bit block offsets
// Notes: register offsets are Avalon word addresses
`ifndef FLASH_GUARD_CONSTS_SVH
`define FLASH_GUARD_CONSTS_SVH
`define REG_CFG_IDX 2'h0
`define REG_GUARD_IDX 2'h1
`define REG_STAT_IDX 2'h2
`define CFG_BANK_LSB 0
`define CFG_BANK_W 2
`define STAT_DONE_BIT 0
`define STAT_ACC_BIT 4
`define STAT_VIOL_BIT 5
`define GUARD_OPEN_BIT 7
`define GUARD_SPARE_BIT 6
`define GUARD_UP_OFF_BIT 5
`define GUARD_UP_SIZE_LSB 3
`define GUARD_LO_OFF_BIT 2
`define GUARD_LO_SIZE_LSB 0
`define GUARD_RESET 8'h00
`define GUARD_ERASED 8'hff
`define NVM_FIRST_ADDR 16'hff0a
`define BLOCK_END 17'h1_0000
`define LOWER_START 17'h0_8000
`define UPPER_MIN_SIZE 17'h0_0800
`define LOWER_MIN_SIZE 17'h0_0200
`endif

//--- verilog/flash_guard_pkg.sv
// Purpose: types shared by the flash block guard
// Assumes: nothing
// Notes: constants live in flash_guard_consts.svh
package flash_guard_pkg;
  typedef enum logic [1:0] {
    LD_ISSUE = 2'b00,
    LD_WAIT = 2'b01,
    LD_DONE = 2'b10
  } ld_state_t;
  typedef enum logic [1:0] {
    CMD_PROG = 2'b00,
    CMD_SECTOR = 2'b01,
    CMD_MASS = 2'b10
  } cmd_kind_t;
endpackage : flash_guard_pkg

//--- verilog/guard_slot.sv
// Purpose: one block guard register, loaded at start-up and tightened by software
// Assumes: load and write never coincide in practice; load wins if they do
// Notes: reset value is fully closed until the load arrives
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_consts.svh"
module guard_slot (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic load_en,
  input wire logic [7:0] load_data,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic special_mode,
  output logic [7:0] value_r
);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      value_r <= `GUARD_RESET;
    end else if (load_en) begin
      value_r <= load_data;
    end else if (wr_en) begin
      // outside special modes bits can only drop, so a cleared open bit sticks
      value_r <= special_mode ? wr_data : (value_r & wr_data);
    end
  end

  tighten_only_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    wr_en && !load_en && !special_mode |=> (value_r & ~$past(value_r)) == 8'h00
  ) else $error("guard bits rose on a normal-mode write");

  slot_load_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    load_en |=> value_r == $past(load_data)
  ) else $error("guard register did not take the loaded byte");
endmodule : guard_slot
`default_nettype wire

//--- verilog/guard_decode.sv
// Purpose: decide whether a command on one block hits a guarded area
// Assumes: 64k-byte block, offset relative to the block base
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_consts.svh"
module guard_decode #(
  parameter int ADDR_W = 16
) (
  input wire logic [7:0] guard,
  input wire logic [ADDR_W-1:0] offset,
  input wire logic mass,
  output logic deny
);
  logic open;
  logic up_off;
  logic lo_off;
  logic [16:0] up_size;
  logic [16:0] lo_size;
  logic [16:0] off17;
  logic in_up;
  logic in_lo;

  if (ADDR_W != 16) begin : g_bad_width
    $error("guard_decode serves 64k-byte blocks only");
  end

  // spare bit 6 is never looked at here
  assign open = guard[`GUARD_OPEN_BIT];
  assign up_off = guard[`GUARD_UP_OFF_BIT];
  assign lo_off = guard[`GUARD_LO_OFF_BIT];
  assign up_size = `UPPER_MIN_SIZE << guard[`GUARD_UP_SIZE_LSB +: 2];
  assign lo_size = `LOWER_MIN_SIZE << guard[`GUARD_LO_SIZE_LSB +: 2];
  assign off17 = {1'b0, offset};
  // upper area ends at the block top and grows down
  assign in_up = off17 >= (`BLOCK_END - up_size);
  // lower area starts 32k below the top and grows up; at most 4k so never meets upper
  assign in_lo = (off17 >= `LOWER_START) && (off17 < (`LOWER_START + lo_size));

  always_comb begin
    if (mass) begin
      deny = !(open && up_off && lo_off);
    end else if (!open) begin
      deny = 1'b1;
    end else begin
      deny = (!up_off && in_up) || (!lo_off && in_lo);
    end
  end
endmodule : guard_decode
`default_nettype wire

//--- verilog/flash_guard.sv
// What this block does
// - one guard register per block, shared address
// - load guard bytes from ff0a onwards at start-up
// - normal modes only clear bits; special modes set
// - lower area starts 32k below block top
// - upper area ends at top, grows down
// - guarded program or erase rejected, violation set
// - mass erase needs open and both areas off
// - open, spare, upper off/size, lower off/size
// - erased byte ff disables all protection
// - open clear guards the whole block
// - open set: areas decide protection alone
// - upper off bit clear guards upper area
// - lower off bit clear guards lower area
// - upper sizes 2k, 4k, 8k, 16k
// - lower sizes 512, 1k, 2k, 4k
// - guard bytes sit in block zero upper area
// - cleared open stays until next reset outside special modes
// - error flags write-one-clear; clear before command
//
// Purpose: per-block flash program/erase guard with Avalon-MM registers
// Assumes: inputs synchronous to clock; one command request per cycle
// Notes: answers each bus access one cycle after it appears, once the guard bytes are loaded
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_consts.svh"
module flash_guard #(
  parameter int NUM_BLOCKS = 4,
  parameter int ADDR_W = 16
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic special_mode,
  output logic nvm_rd_req,
  output logic [15:0] nvm_rd_addr,
  input wire logic [7:0] nvm_rd_data,
  input wire logic nvm_rd_valid,
  input wire logic cmd_valid,
  input wire flash_guard_pkg::cmd_kind_t cmd_kind,
  input wire logic [ADDR_W-1:0] cmd_offset,
  output logic cmd_accept,
  output logic cmd_reject,
  output logic load_done
);
  if (NUM_BLOCKS < 1 || NUM_BLOCKS > 4) begin : g_bad_blocks
    $error("NUM_BLOCKS must be 1 to 4");
  end

  flash_guard_pkg::ld_state_t ld_state_r;
  flash_guard_pkg::ld_state_t ld_state_nxt;
  logic [1:0] ld_idx_r;
  logic [1:0] ld_block;
  logic [1:0] bank_sel_r;
  logic bank_ok;
  logic viol_r;
  logic acc_r;
  logic [7:0] guard_v [NUM_BLOCKS];
  logic [NUM_BLOCKS-1:0] deny_v;
  logic [7:0] sel_guard;
  logic sel_deny;
  logic bus_req;
  logic bus_ack;
  logic wr_ack;
  logic flags_busy;
  logic cmd_take;
  logic cmd_denied;
  logic cmd_late;
  logic viol_set;
  logic acc_set;
  logic viol_clr;
  logic acc_clr;
  logic [31:0] rd_nxt;
  logic [1:0] last_idx;

  assign last_idx = 2'(NUM_BLOCKS - 1);
  // first byte read belongs to the highest-numbered block
  assign ld_block = last_idx - ld_idx_r;

  // start-up loader: one byte per block, blocking the bus and commands until done
  always_comb begin
    ld_state_nxt = ld_state_r;
    case (ld_state_r)
      flash_guard_pkg::LD_ISSUE: begin
        ld_state_nxt = flash_guard_pkg::LD_WAIT;
      end
      flash_guard_pkg::LD_WAIT: begin
        if (nvm_rd_valid) begin
          ld_state_nxt = (ld_idx_r == last_idx) ? flash_guard_pkg::LD_DONE
                                                 : flash_guard_pkg::LD_ISSUE;
        end
      end
      flash_guard_pkg::LD_DONE: begin
        ld_state_nxt = flash_guard_pkg::LD_DONE;
      end
      default: begin
        ld_state_nxt = flash_guard_pkg::LD_ISSUE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ld_state_r <= flash_guard_pkg::LD_ISSUE;
    end else begin
      ld_state_r <= ld_state_nxt;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ld_idx_r <= 2'h0;
    end else if (ld_state_r == flash_guard_pkg::LD_WAIT && nvm_rd_valid
                 && ld_idx_r != last_idx) begin
      ld_idx_r <= ld_idx_r + 2'h1;
    end
  end

  // request held from issue until the byte comes back
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      nvm_rd_req <= 1'b0;
      nvm_rd_addr <= `NVM_FIRST_ADDR;
    end else if (ld_state_r == flash_guard_pkg::LD_ISSUE) begin
      nvm_rd_req <= 1'b1;
      nvm_rd_addr <= `NVM_FIRST_ADDR + {14'h0000, ld_idx_r};
    end else if (nvm_rd_valid) begin
      nvm_rd_req <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      load_done <= 1'b0;
    end else begin
      load_done <= (ld_state_nxt == flash_guard_pkg::LD_DONE);
    end
  end

  // bus: once loading is done each access waits one cycle, so the answer is registered
  assign bus_req = avs_read || avs_write;
  assign bus_ack = bus_req && !avs_waitrequest;
  assign wr_ack = avs_write && !avs_waitrequest;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest && load_done);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bank_sel_r <= 2'h0;
    end else if (wr_ack && avs_address == `REG_CFG_IDX && avs_byteenable[0]) begin
      bank_sel_r <= avs_writedata[`CFG_BANK_LSB +: `CFG_BANK_W];
    end
  end

  assign bank_ok = {30'h0000_0000, bank_sel_r} < NUM_BLOCKS;
  assign sel_guard = bank_ok ? guard_v[bank_sel_r] : 8'h00;
  assign sel_deny = bank_ok ? deny_v[bank_sel_r] : 1'b1;

  // one register and one decoder per block, all seen through the bank select
  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_block
    guard_slot u_slot (
      .clock(clock),
      .arst_n(arst_n),
      .load_en(ld_state_r == flash_guard_pkg::LD_WAIT && nvm_rd_valid
               && ld_block == 2'(b)),
      .load_data(nvm_rd_data),
      .wr_en(wr_ack && avs_address == `REG_GUARD_IDX && avs_byteenable[0]
             && bank_sel_r == 2'(b)),
      .wr_data(avs_writedata[7:0]),
      .special_mode(special_mode),
      .value_r(guard_v[b])
    );
    guard_decode #(.ADDR_W(ADDR_W)) u_decode (
      .guard(guard_v[b]),
      .offset(cmd_offset),
      .mass(cmd_kind == flash_guard_pkg::CMD_MASS),
      .deny(deny_v[b])
    );
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (avs_address)
      `REG_CFG_IDX: rd_nxt[`CFG_BANK_LSB +: `CFG_BANK_W] = bank_sel_r;
      `REG_GUARD_IDX: rd_nxt[7:0] = sel_guard;
      `REG_STAT_IDX: begin
        rd_nxt[`STAT_VIOL_BIT] = viol_r;
        rd_nxt[`STAT_ACC_BIT] = acc_r;
        rd_nxt[`STAT_DONE_BIT] = load_done;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_nxt;
    end
  end

  // command check against the selected block
  assign flags_busy = viol_r || acc_r;
  assign cmd_late = cmd_valid && !load_done;
  assign cmd_take = cmd_valid && load_done;
  assign cmd_denied = cmd_take && !flags_busy && sel_deny;
  // launching with a flag still standing is an access error
  assign acc_set = cmd_late || (cmd_take && flags_busy);
  assign viol_set = cmd_denied;
  assign viol_clr = wr_ack && avs_address == `REG_STAT_IDX && avs_byteenable[0]
                    && avs_writedata[`STAT_VIOL_BIT];
  assign acc_clr = wr_ack && avs_address == `REG_STAT_IDX && avs_byteenable[0]
                   && avs_writedata[`STAT_ACC_BIT];

  // a fresh event in the clearing cycle wins over the clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      viol_r <= 1'b0;
    end else if (viol_set) begin
      viol_r <= 1'b1;
    end else if (viol_clr) begin
      viol_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= 1'b0;
    end else if (acc_set) begin
      acc_r <= 1'b1;
    end else if (acc_clr) begin
      acc_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_accept <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_accept <= cmd_take && !flags_busy && !sel_deny;
      cmd_reject <= cmd_valid && (flags_busy || sel_deny || !load_done);
    end
  end

  sequence clean_cmd_s;
    cmd_take && !flags_busy;
  endsequence

  sequence rejected_s;
    cmd_reject && !cmd_accept;
  endsequence

  viol_reject_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    clean_cmd_s and sel_deny |=> rejected_s ##0 viol_r
  ) else $error("guarded command not rejected with violation");

  mass_erased_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    clean_cmd_s and (cmd_kind == flash_guard_pkg::CMD_MASS && sel_guard == `GUARD_ERASED)
    |=> cmd_accept
  ) else $error("mass erase refused on an erased guard byte");

  mass_guard_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    clean_cmd_s and (cmd_kind == flash_guard_pkg::CMD_MASS && !sel_guard[`GUARD_LO_OFF_BIT])
    |=> rejected_s
  ) else $error("mass erase allowed with lower area guarded");

  closed_block_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    clean_cmd_s and !sel_guard[`GUARD_OPEN_BIT] |=> rejected_s
  ) else $error("command allowed on a closed block");

  top_word_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    clean_cmd_s and (sel_guard[`GUARD_UP_OFF_BIT] == 1'b0 && cmd_offset == 16'hffff)
    |=> rejected_s
  ) else $error("top of block not guarded by the upper area");

  flag_clear_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    viol_clr && !viol_set |=> !viol_r ##1 (!viol_r || $past(viol_set))
  ) else $error("violation flag not cleared by a one");

  bank_read_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    avs_read && avs_waitrequest && load_done && avs_address == `REG_GUARD_IDX
    |=> !avs_waitrequest && avs_readdata[7:0] == $past(sel_guard)
  ) else $error("guard read not answered from the selected bank");

  load_order_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    nvm_rd_req && nvm_rd_valid && nvm_rd_addr == `NVM_FIRST_ADDR + 16'(NUM_BLOCKS - 1)
    |=> load_done
  ) else $error("load not finished after the last guard byte");

  sequence acc_reject_s;
    rejected_s ##0 acc_r;
  endsequence

  early_cmd_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    cmd_late |=> acc_reject_s
  ) else $error("command before load not refused as an access error");

  busy_cmd_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    cmd_take && flags_busy |=> acc_reject_s
  ) else $error("command with a standing flag not refused");

  one_answer_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    cmd_valid |=> cmd_accept != cmd_reject
  ) else $error("command not answered by exactly one of accept or reject");

  ack_pulse_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    bus_ack |=> avs_waitrequest
  ) else $error("bus acknowledge lasted more than one cycle");

  load_hold_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !load_done |-> avs_waitrequest
  ) else $error("bus answered before the guard bytes were loaded");

  guard_write_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    wr_ack && avs_address == `REG_GUARD_IDX && avs_byteenable[0] && bank_ok && special_mode
    |=> sel_guard == $past(avs_writedata[7:0])
  ) else $error("special-mode guard write not taken");
endmodule : flash_guard
`default_nettype wire

//--- bench/flash_nvm_model.sv
// Purpose: flash array side of the guard loader, answers each byte request from an image
// Assumes: image byte k sits at ff0a+k; one request outstanding at a time
// Notes: wait_cycles sets how slowly the array answers
`timescale 1ns/10ps
`default_nettype none
module flash_nvm_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic nvm_rd_req,
  input wire logic [15:0] nvm_rd_addr,
  input wire logic [31:0] image,
  input wire logic [3:0] wait_cycles,
  output logic [7:0] nvm_rd_data,
  output logic nvm_rd_valid
);
  logic [3:0] wait_r;
  logic [1:0] slot;
  // ff0a ends in binary 10, so subtracting 2 gives the image byte index
  assign slot = 2'(nvm_rd_addr[1:0] - 2'h2);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 4'h0;
      nvm_rd_valid <= 1'b0;
      nvm_rd_data <= 8'h5a;
    end else if (nvm_rd_valid) begin
      // one-cycle answer, then the data lines stop showing the byte
      nvm_rd_valid <= 1'b0;
      nvm_rd_data <= ~nvm_rd_data;
      wait_r <= 4'h0;
    end else if (nvm_rd_req && wait_r >= wait_cycles) begin
      nvm_rd_valid <= 1'b1;
      nvm_rd_data <= image[8*slot +: 8];
    end else begin
      nvm_rd_data <= ~nvm_rd_data;
      if (nvm_rd_req) begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule : flash_nvm_model
`default_nettype wire

//--- bench/tb.sv
// Purpose: self-checking bench for the flash block guard
// Assumes: four blocks, bus answers one access at a time
// Notes: guard decode cases run as table rows under special mode
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {logic [7:0] g; logic [1:0] k; logic [15:0] off; logic rej;} row_t;
  logic clock, arst_n, avs_read, avs_write, special_mode, cmd_valid, avs_waitrequest;
  logic nvm_rd_req, nvm_rd_valid, cmd_accept, cmd_reject, load_done;
  logic [1:0] avs_address;
  logic [3:0] avs_byteenable, wait_cycles;
  logic [31:0] avs_writedata, avs_readdata, image, rd;
  logic [15:0] nvm_rd_addr, cmd_offset;
  logic [7:0] nvm_rd_data;
  flash_guard_pkg::cmd_kind_t cmd_kind;
  int miscompares, checks_done, ld_idx;
  row_t rows [30] = '{
    '{8'hff,2'h0,16'h0000,1'b0}, '{8'hff,2'h2,16'h0000,1'b0},
    '{8'h7f,2'h0,16'h1234,1'b1}, '{8'h7f,2'h2,16'h0000,1'b1},
    '{8'hbf,2'h2,16'h0000,1'b0}, '{8'hc0,2'h0,16'hffff,1'b1},
    '{8'hc0,2'h1,16'hf800,1'b1}, '{8'hc0,2'h0,16'hf7ff,1'b0},
    '{8'hc8,2'h0,16'hf000,1'b1}, '{8'hc8,2'h0,16'hefff,1'b0},
    '{8'hd0,2'h0,16'he000,1'b1}, '{8'hd0,2'h0,16'hdfff,1'b0},
    '{8'hd8,2'h1,16'hc000,1'b1}, '{8'hd8,2'h0,16'hbfff,1'b0},
    '{8'hc0,2'h0,16'h8000,1'b1}, '{8'hc0,2'h0,16'h7fff,1'b0},
    '{8'hc0,2'h0,16'h81ff,1'b1}, '{8'hc0,2'h0,16'h8200,1'b0},
    '{8'hc1,2'h0,16'h83ff,1'b1}, '{8'hc1,2'h0,16'h8400,1'b0},
    '{8'hc2,2'h1,16'h87ff,1'b1}, '{8'hc2,2'h0,16'h8800,1'b0},
    '{8'hc3,2'h0,16'h8fff,1'b1}, '{8'hc3,2'h0,16'h9000,1'b0},
    '{8'he0,2'h0,16'hffff,1'b0}, '{8'hc4,2'h0,16'h8000,1'b0},
    '{8'hdf,2'h2,16'h0000,1'b1}, '{8'hfb,2'h2,16'h0000,1'b1},
    '{8'hc0,2'h0,16'hff0d,1'b1}, '{8'hc0,2'h1,16'h4000,1'b0}
  };

  flash_guard uut (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .special_mode(special_mode),
    .nvm_rd_req(nvm_rd_req), .nvm_rd_addr(nvm_rd_addr), .nvm_rd_data(nvm_rd_data),
    .nvm_rd_valid(nvm_rd_valid), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_offset(cmd_offset), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
    .load_done(load_done));
  flash_nvm_model far_end (.clock(clock), .arst_n(arst_n), .nvm_rd_req(nvm_rd_req),
    .nvm_rd_addr(nvm_rd_addr), .image(image), .wait_cycles(wait_cycles),
    .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus_cycle(input logic wr, input logic [1:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (n >= 200) check(32'h0000_0000, 32'h0000_0001, "bus answer timeout");
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus_cycle

  task automatic do_cmd(input logic [1:0] k, input logic [15:0] off, input logic rej);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_kind <= flash_guard_pkg::cmd_kind_t'(k);
    cmd_offset <= off;
    @(posedge clock);
    cmd_valid <= 1'b0;
    #1;
    check({30'h0, cmd_accept, cmd_reject}, {30'h0, ~rej, rej}, "command answer");
  endtask : do_cmd

  task automatic do_reset(input logic [31:0] img, input logic [3:0] w);
    int n;
    @(posedge clock);
    arst_n <= 1'b0;
    image <= img;
    wait_cycles <= w;
    repeat (4) @(posedge clock);
    check({27'h0, avs_waitrequest, load_done, cmd_accept, cmd_reject, nvm_rd_req},
          32'h0000_0010, "reset outputs");
    arst_n <= 1'b1;
    // a command while the bytes are still loading must be refused
    if (w != 4'h0) do_cmd(2'h0, 16'h0000, 1'b1);
    n = 0;
    while (load_done !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    check({31'h0, load_done}, 32'h0000_0001, "load finished");
  endtask : do_reset

  // loader must walk the protection bytes upward from ff0a
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) ld_idx <= 0;
    else if (nvm_rd_valid && nvm_rd_req) begin
      check({16'h0, nvm_rd_addr}, {16'h0, 16'hff0a + 16'(ld_idx)}, "load address");
      ld_idx <= ld_idx + 1;
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    results();
  end

  initial begin
    miscompares = 0;
    checks_done = 0;
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 2'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
    special_mode = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = flash_guard_pkg::CMD_PROG;
    cmd_offset = 16'h0000;
    image = 32'hffff_ffff;
    wait_cycles = 4'h0;
    do_reset(32'hffff_ffff, 4'h0);
    for (int b = 0; b < 4; b++) begin
      bus_cycle(1'b1, 2'h0, 8'(b));
      bus_cycle(1'b0, 2'h1, 8'h00);
      check(rd, 32'h0000_00ff, "erased guard");
    end
    bus_cycle(1'b0, 2'h2, 8'h00);
    check(rd, 32'h0000_0001, "status idle");
    bus_cycle(1'b1, 2'h0, 8'h01);
    bus_cycle(1'b1, 2'h1, 8'h0f);
    bus_cycle(1'b1, 2'h1, 8'hf0);
    bus_cycle(1'b0, 2'h1, 8'h00);
    check(rd, 32'h0000_0000, "normal write only clears");
    special_mode <= 1'b1;
    bus_cycle(1'b1, 2'h1, 8'hff);
    bus_cycle(1'b0, 2'h1, 8'h00);
    check(rd, 32'h0000_00ff, "special write sets");
    bus_cycle(1'b1, 2'h0, 8'h00);
    foreach (rows[i]) begin
      bus_cycle(1'b1, 2'h1, rows[i].g);
      do_cmd(rows[i].k, rows[i].off, rows[i].rej);
      bus_cycle(1'b0, 2'h2, 8'h00);
      check({31'h0, rd[5]}, {31'h0, rows[i].rej}, "violation flag");
      if (rows[i].rej) bus_cycle(1'b1, 2'h2, 8'h30);
    end
    // a standing violation turns the next command into an access error
    bus_cycle(1'b1, 2'h1, 8'h7f);
    do_cmd(2'h0, 16'h0000, 1'b1);
    do_cmd(2'h0, 16'h0000, 1'b1);
    bus_cycle(1'b0, 2'h2, 8'h00);
    check(rd, 32'h0000_0031, "both flags");
    bus_cycle(1'b1, 2'h2, 8'h30);
    bus_cycle(1'b0, 2'h2, 8'h00);
    check(rd, 32'h0000_0001, "flags cleared");
    bus_cycle(1'b1, 2'h1, 8'hff);
    special_mode <= 1'b0;
    bus_cycle(1'b1, 2'h1, 8'h7f);
    bus_cycle(1'b1, 2'h1, 8'hff);
    bus_cycle(1'b0, 2'h1, 8'h00);
    check(rd, 32'h0000_007f, "closed stays closed");
    do_cmd(2'h0, 16'h1000, 1'b1);
    bus_cycle(1'b1, 2'h2, 8'h30);
    bus_cycle(1'b1, 2'h3, 8'hff);
    bus_cycle(1'b0, 2'h3, 8'h00);
    check(rd, 32'h0000_0000, "unmapped reads zero");
    do_reset(32'hd4c3_b2a1, 4'h5);
    bus_cycle(1'b0, 2'h2, 8'h00);
    check(rd, 32'h0000_0011, "early command flagged");
    bus_cycle(1'b1, 2'h2, 8'h30);
    for (int b = 0; b < 4; b++) begin
      bus_cycle(1'b1, 2'h0, 8'(b));
      bus_cycle(1'b0, 2'h1, 8'h00);
      check(rd, {24'h00_0000, image[8*(3-b) +: 8]}, "loaded guard");
    end
    // boot code kept in the upper area of block zero stays out of reach
    bus_cycle(1'b1, 2'h0, 8'h00);
    do_cmd(2'h0, 16'hfffe, 1'b1);
    bus_cycle(1'b1, 2'h2, 8'h30);
    // block one reloads as open with both areas guarded; offset 1000 lies outside them
    bus_cycle(1'b1, 2'h0, 8'h01);
    do_cmd(2'h0, 16'h1000, 1'b0);
    results();
  end
endmodule : tb
`default_nettype wire
